// >>> rtl/saf_filter.sv
// Purpose: loads the destination filter from setup frames and filters received addresses
// Assumes: the transmit side hands setup buffer words in order, one per accepted transfer
// Notes: perfect, inverse and hash modes; one result per destination presented while receive is attached
//
// Functional notes
// (R01) setup frame is never sent to the medium nor looped back to receive.
// (R02) receive side is detached from the medium while a setup frame loads.
// (R03) host supplies setup frames of exactly 192 bytes.
// (R04) host gives one aligned buffer with first and last segment flags clear.
// (R05) on completion the status word closes with owner clear, all else one.
// (R06) host loads a setup frame before starting reception unless promiscuous.
// (R07) later setup frames follow ring start or a zero-length owned descriptor.
// (R08) zero-length setup descriptor repeats previous filtering type flags.
// (R09) setup waits for running transmit, drained queue and finished reception.
// (R10) setup handling leaves the receive process state untouched.
// (R11) hash select clear: sixteen 48-bit addresses compared with every destination.
// (R12) perfect mode rejects non-matches; inverse sense rejects matches instead.
// (R13) host fills all sixteen slots, duplicating a valid entry when unused.
// (R14) each address takes three words, two bytes in low halves, low bytes first.
// (R15) bit 0 of the first address byte marks a group address.
// (R16) hash select set: load 512-bit hash table plus one unicast address.
// (R17) imperfect mode hashes group frames, unicast must equal the stored address.
// (R18) crc over six destination bytes, top nine bits index the table.
// (R19) table bits count upward inside a word, then on into following words.
// (R20) table in low halves of words 0 to 31, unicast in words 39 to 41.
`timescale 1ns/1ps
`include "saf_params.svh"
module saf_filter (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic setup_req_in,
  input wire logic setup_first_seg_in,
  input wire logic setup_last_seg_in,
  input wire logic [10:0] setup_buf_size_in,
  input wire logic tx_running_in,
  input wire logic tx_queue_empty_in,
  input wire logic rx_frame_active_in,
  input wire logic hash_sel_in,
  input wire logic inverse_in,
  input wire logic word_valid_in,
  input wire logic [31:0] word_in,
  input wire logic rx_da_valid_in,
  input wire logic [47:0] rx_da_in,
  output logic word_ready_out,
  output logic rx_detach_out,
  output logic tx_suppress_out,
  output logic setup_bad_out,
  output logic wb_valid_out,
  output logic [31:0] wb_status_out,
  output logic filt_valid_out,
  output logic filt_accept_out
);
  import saf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state and storage

  saf_state_t state;
  saf_state_t next_state;
  logic [5:0] word_idx;
  logic [3:0] ent;
  logic [1:0] part;
  logic load_hash;
  saf_addr_tab_t tab;
  logic [`SAF_HASH_BITS-1:0] hash_tab;

  ////////////////////////////////////////////////////////////////////////////
  // lookup helpers

  saf_lookup_if lk ();

  saf_crc_hash u_crc (
    .lk(lk)
  );

  saf_addr_match u_match (
    .lk(lk),
    .tab_in(tab)
  );

  assign lk.da = rx_da_in;

  ////////////////////////////////////////////////////////////////////////////
  // request decode

  logic desc_ok;
  logic start_ok;
  logic word_take;
  logic last_word;
  logic req_take;

  // a malformed setup descriptor is refused, never half loaded
  assign desc_ok = (setup_buf_size_in == `SAF_SETUP_BYTES) // [R03]
    & ~setup_first_seg_in & ~setup_last_seg_in; // [R04]
  // wait for running transmit, empty queue and no frame mid-reception
  assign start_ok = tx_running_in & tx_queue_empty_in & ~rx_frame_active_in; // [R09]
  assign req_take = (state == SAF_IDLE) & setup_req_in;
  assign word_take = word_valid_in & word_ready_out;
  assign last_word = (word_idx == `SAF_LAST_WORD);

  ////////////////////////////////////////////////////////////////////////////
  // setup sequencing

  // requests arriving while a setup is in flight are ignored
  always_comb begin
    next_state = state;
    case (state)
      SAF_IDLE: begin
        if (setup_req_in && desc_ok) begin
          next_state = SAF_WAIT;
        end
      end
      SAF_WAIT: begin
        if (start_ok) begin
          next_state = SAF_LOAD; // [R09]
        end
      end
      SAF_LOAD: begin
        if (word_take && last_word) begin
          next_state = SAF_CLOSE;
        end
      end
      SAF_CLOSE: begin
        next_state = SAF_IDLE;
      end
      default: begin
        next_state = SAF_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state <= SAF_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // word position tracking

  logic [5:0] next_word_idx;
  logic [3:0] next_ent;
  logic [1:0] next_part;
  logic part_wrap;

  // entry and part counters avoid a divide by three on the word index
  assign part_wrap = (part == `SAF_ENTRY_PARTS);
  assign next_word_idx = (state != SAF_LOAD) ? 6'h00 : word_take ? word_idx + 6'h01 : word_idx;
  assign next_part = (state != SAF_LOAD) ? 2'h0 : !word_take ? part : part_wrap ? 2'h0 : part + 2'h1;
  assign next_ent = (state != SAF_LOAD) ? 4'h0 : (word_take && part_wrap) ? ent + 4'h1 : ent;

  // counters clear outside a load so every frame starts at word zero
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      word_idx <= 6'h00;
      part <= 2'h0;
      ent <= 4'h0;
    end else begin
      word_idx <= next_word_idx;
      part <= next_part;
      ent <= next_ent;
    end
  end

  // layout is fixed when the request is taken, not by later mode changes
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      load_hash <= 1'b0;
    end else if (req_take) begin
      load_hash <= hash_sel_in; // [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // table write decode

  logic uni_word;
  logic hash_word;
  logic tab_wr;
  logic hash_wr;
  logic [5:0] uni_off;
  logic [3:0] wr_ent;
  logic [1:0] wr_part;

  // hash layout: table words first, unicast address further down
  assign hash_word = (word_idx < `SAF_HASH_WORDS); // [R20]
  assign uni_word = (word_idx >= `SAF_UNI_FIRST) & (word_idx <= `SAF_UNI_LAST); // [R20]
  assign uni_off = word_idx - `SAF_UNI_FIRST;
  assign hash_wr = word_take & load_hash & hash_word; // [R16]
  assign tab_wr = word_take & (~load_hash | uni_word); // [R14]
  // the single unicast address reuses slot zero of the perfect table
  assign wr_ent = load_hash ? 4'h0 : ent; // [R17]
  assign wr_part = load_hash ? uni_off[1:0] : part; // [R14]

  // two address bytes per word, upper half ignored, low bytes first
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < `SAF_NUM_ENTRIES; i++) begin
        tab[i] <= 48'h0000_0000_0000;
      end
    end else if (tab_wr) begin
      tab[wr_ent][{wr_part, 4'h0} +: 16] <= word_in[15:0]; // [R14]
    end
  end

  // table bit n sits in word n/16 at bit n%16 of the low half
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      hash_tab <= '0;
    end else if (hash_wr) begin
      hash_tab[{word_idx[4:0], 4'h0} +: 16] <= word_in[15:0]; // [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // medium isolation and descriptor close

  logic next_detach;
  logic next_suppress;
  logic close_now;

  // receive sees no medium from first word until the close cycle ends
  assign next_detach = (next_state == SAF_LOAD) | (next_state == SAF_CLOSE); // [R02]
  // the setup frame is held away from the wire and the loopback path
  assign next_suppress = (next_state != SAF_IDLE); // [R01]
  assign close_now = (state == SAF_LOAD) & word_take & last_word;

  // isolation flags, word request handshake and refusal pulse
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rx_detach_out <= 1'b0;
      tx_suppress_out <= 1'b0;
      word_ready_out <= 1'b0;
      setup_bad_out <= 1'b0;
    end else begin
      rx_detach_out <= next_detach; // [R02]
      tx_suppress_out <= next_suppress; // [R01]
      word_ready_out <= (next_state == SAF_LOAD);
      setup_bad_out <= req_take & ~desc_ok; // [R03]
    end
  end

  // status word written back once, owner bit cleared and all others set
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wb_valid_out <= 1'b0;
      wb_status_out <= 32'h0000_0000;
    end else begin
      wb_valid_out <= close_now; // [R05]
      if (close_now) begin
        wb_status_out <= `SAF_CLOSE_STATUS; // [R05]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // destination filtering

  logic group_da;
  logic any_hit;
  logic perf_accept;
  logic hash_accept;
  logic accept;
  logic da_take;

  assign group_da = rx_da_in[0]; // [R15]
  assign any_hit = |lk.hit; // [R11]
  assign perf_accept = inverse_in ? ~any_hit : any_hit; // [R12]
  // hashing is imperfect: unwanted group frames may slip through
  assign hash_accept = group_da ? hash_tab[lk.hash_idx] : lk.hit[0]; // [R17] [R18]
  assign accept = hash_sel_in ? hash_accept : perf_accept; // [R11] [R16]
  // while detached nothing is judged; receive state itself is never touched here
  assign da_take = rx_da_valid_in & ~rx_detach_out; // [R02] [R10]

  // one registered verdict per destination presented while attached
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      filt_valid_out <= 1'b0;
      filt_accept_out <= 1'b0;
    end else begin
      filt_valid_out <= da_take;
      if (da_take) begin
        filt_accept_out <= accept;
      end
    end
  end
endmodule // saf_filter

// >>> rtl/saf_params.svh
// Purpose: constants of the setup frame address filter
// Assumes: one 32-bit setup buffer word is handed over per transfer
// Notes: definitions only
`ifndef SAF_PARAMS_SVH
`define SAF_PARAMS_SVH
`define SAF_SETUP_BYTES 11'h0C0
`define SAF_LAST_WORD 6'h2F
`define SAF_NUM_ENTRIES 16
`define SAF_ENTRY_PARTS 2'h2
`define SAF_HASH_BITS 512
`define SAF_HASH_WORDS 6'h20
`define SAF_UNI_FIRST 6'h27
`define SAF_UNI_LAST 6'h29
`define SAF_CLOSE_STATUS 32'h7FFF_FFFF
`define SAF_CRC_INIT 32'hFFFF_FFFF
`define SAF_CRC_POLY 32'hEDB8_8320
`endif

// >>> rtl/saf_pkg.sv
// Purpose: types shared by the address filter modules
// Assumes: saf_params.svh on the include path
// Notes: byte 0 of an address sits in bits 7:0
`include "saf_params.svh"
package saf_pkg;
  typedef logic [47:0] saf_addr_t;
  typedef saf_addr_t saf_addr_tab_t [`SAF_NUM_ENTRIES];
  typedef enum logic [1:0] {
    SAF_IDLE = 2'b00,
    SAF_WAIT = 2'b01,
    SAF_LOAD = 2'b10,
    SAF_CLOSE = 2'b11
  } saf_state_t;
endpackage

// >>> rtl/saf_lookup_if.sv
// Purpose: carries the destination under test and the lookup answers
// Assumes: purely combinational signals
// Notes: one modport per party
`timescale 1ns/1ps
`include "saf_params.svh"
interface saf_lookup_if;
  import saf_pkg::*;
  saf_addr_t da;
  logic [8:0] hash_idx;
  logic [`SAF_NUM_ENTRIES-1:0] hit;
  modport filt (output da, input hash_idx, input hit);
  modport crc (input da, output hash_idx);
  modport cmp (input da, output hit);
endinterface

// >>> rtl/saf_crc_hash.sv
// Purpose: hash index of a destination address
// Assumes: bits go in byte 0 first, least significant bit first
// Notes: combinational, one bit step per loop pass
`timescale 1ns/1ps
`include "saf_params.svh"
module saf_crc_hash (
  saf_lookup_if.crc lk
);
  import saf_pkg::*;
  // serial network crc unrolled over the six destination bytes
  function automatic logic [31:0] saf_crc48(input saf_addr_t a);
    logic [31:0] c;
    logic fb;
    c = `SAF_CRC_INIT;
    fb = 1'b0;
    for (int i = 0; i < 48; i++) begin
      fb = c[0] ^ a[i];
      c = {1'b0, c[31:1]} ^ (fb ? `SAF_CRC_POLY : 32'h0000_0000);
    end
    return c;
  endfunction
  logic [31:0] crc_val;
  // reflected register: its low nine bits are the top nine of the polynomial result
  assign crc_val = saf_crc48(lk.da); // [R18]
  assign lk.hash_idx = crc_val[8:0]; // [R18]
endmodule // saf_crc_hash

// >>> rtl/saf_addr_match.sv
// Purpose: compares a destination against every stored address
// Assumes: table held by the caller
// Notes: one comparator per entry
`timescale 1ns/1ps
`include "saf_params.svh"
module saf_addr_match (
  saf_lookup_if.cmp lk,
  input saf_pkg::saf_addr_tab_t tab_in
);
  import saf_pkg::*;
  // sixteen full 48-bit compares in parallel
  for (genvar i = 0; i < `SAF_NUM_ENTRIES; i++) begin : g_cmp
    assign lk.hit[i] = (tab_in[i] == lk.da); // [R11]
  end
endmodule // saf_addr_match

// >>> tb/saf_filter_props.sv
// Purpose: port level checker for saf_filter
// Assumes: sees only the top module ports
// Notes: bound to saf_filter after the module
`timescale 1ns/1ps
`include "saf_params.svh"
module saf_filter_props (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic setup_req_in,
  input wire logic setup_first_seg_in,
  input wire logic setup_last_seg_in,
  input wire logic [10:0] setup_buf_size_in,
  input wire logic tx_running_in,
  input wire logic tx_queue_empty_in,
  input wire logic rx_frame_active_in,
  input wire logic word_valid_in,
  input wire logic rx_da_valid_in,
  input wire logic word_ready_out,
  input wire logic rx_detach_out,
  input wire logic tx_suppress_out,
  input wire logic setup_bad_out,
  input wire logic wb_valid_out,
  input wire logic [31:0] wb_status_out,
  input wire logic filt_valid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // an idle request is one seen while nothing is suppressed
  wire idle_req = setup_req_in && !tx_suppress_out;
  wire good_req = setup_buf_size_in == `SAF_SETUP_BYTES && !setup_first_seg_in && !setup_last_seg_in;
  wire start_ok = tx_running_in && tx_queue_empty_in && !rx_frame_active_in;
  logic [5:0] n_words;
  // words taken in the current load, cleared at close
  always_ff @(posedge clk_in) begin
    if (!rstn_in || wb_valid_out) n_words <= 6'h00;
    else if (word_ready_out && word_valid_in) n_words <= n_words + 6'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_release;
    ##1 !rx_detach_out && !tx_suppress_out;
  endsequence
  property p_refuse;
    idle_req && !good_req |=> setup_bad_out && !tx_suppress_out;
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad setup request not refused");
  property p_accept;
    idle_req && good_req |=> tx_suppress_out && !setup_bad_out;
  endproperty
  a_accept: assert property (p_accept) else $error("setup frame not kept off the wire");
  property p_drop;
    rx_detach_out && rx_da_valid_in |=> !filt_valid_out;
  endproperty
  a_drop: assert property (p_drop) else $error("destination judged while detached");
  property p_judge;
    rx_da_valid_in && !rx_detach_out |=> filt_valid_out;
  endproperty
  a_judge: assert property (p_judge) else $error("destination not judged");
  property p_close;
    wb_valid_out |-> wb_status_out == `SAF_CLOSE_STATUS && n_words == 6'd48;
  endproperty
  a_close: assert property (p_close) else $error("bad close of setup descriptor");
  property p_wait;
    tx_suppress_out && !rx_detach_out && !start_ok |=> !word_ready_out;
  endproperty
  a_wait: assert property (p_wait) else $error("load started too early");
  property p_end;
    $fell(word_ready_out) |-> wb_valid_out ##0 s_release;
  endproperty
  a_end: assert property (p_end) else $error("load did not end cleanly");
  property p_detach;
    word_ready_out |-> rx_detach_out && tx_suppress_out;
  endproperty
  a_detach: assert property (p_detach) else $error("receive attached during load");
endmodule // saf_filter_props
bind saf_filter saf_filter_props chk_u (.clk_in, .rstn_in, .setup_req_in, .setup_first_seg_in,
  .setup_last_seg_in, .setup_buf_size_in, .tx_running_in, .tx_queue_empty_in, .rx_frame_active_in,
  .word_valid_in, .rx_da_valid_in, .word_ready_out, .rx_detach_out, .tx_suppress_out, .setup_bad_out,
  .wb_valid_out, .wb_status_out, .filt_valid_out);

// >>> tb/saf_host_model.sv
// Purpose: host memory side handing setup buffer words over
// Assumes: buffer contents prepared by the bench
// Notes: can stall every other cycle like a slow memory
`timescale 1ns/1ps
module saf_host_model (
  input wire logic clk_in,
  input wire logic ready_in,
  input wire logic stall_in,
  input wire logic [31:0] buf_in [48],
  output logic valid_out,
  output logic [31:0] word_out
);
  logic [5:0] idx;
  logic tog;
  // stale words are inverted so they never pass for data
  assign valid_out = !(stall_in && tog);
  assign word_out = valid_out ? buf_in[idx] : ~buf_in[idx];
  // one aligned 192 byte buffer, 48 words in order
  always_ff @(posedge clk_in) begin
    tog <= ready_in && !tog;
    if (!ready_in) idx <= 6'h00;
    else if (valid_out) idx <= idx + 6'h01;
  end
endmodule // saf_host_model

// >>> tb/saf_filter_tb.sv
// Purpose: self checking bench for saf_filter
// Assumes: host model streams the setup buffer
// Notes: perfect and hash loads, inverse checks and refusals
`timescale 1ns/1ps
`include "saf_params.svh"
module saf_filter_tb;
  import saf_pkg::*;
  logic clk_in, rstn_in, setup_req_in, setup_first_seg_in, setup_last_seg_in, tx_running_in, stall;
  logic tx_queue_empty_in, rx_frame_active_in, hash_sel_in, inverse_in, word_valid_in, rx_da_valid_in;
  logic word_ready_out, rx_detach_out, tx_suppress_out, setup_bad_out, wb_valid_out, filt_valid_out, filt_accept_out;
  logic [10:0] setup_buf_size_in;
  logic [31:0] word_in, wb_status_out;
  logic [31:0] mem [48];
  saf_addr_t rx_da_in, a, miss, ma1, ma2, uni;
  logic [8:0] h1;
  int fail_count, n_tests, cyc;
  saf_filter dut_u (.clk_in, .rstn_in, .setup_req_in, .setup_first_seg_in, .setup_last_seg_in,
    .setup_buf_size_in, .tx_running_in, .tx_queue_empty_in, .rx_frame_active_in, .hash_sel_in, .inverse_in,
    .word_valid_in, .word_in, .rx_da_valid_in, .rx_da_in, .word_ready_out, .rx_detach_out, .tx_suppress_out,
    .setup_bad_out, .wb_valid_out, .wb_status_out, .filt_valid_out, .filt_accept_out);
  saf_host_model host_u (.clk_in, .ready_in(word_ready_out), .stall_in(stall), .buf_in(mem),
    .valid_out(word_valid_in), .word_out(word_in));
  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; the run needs well under a thousand cycles
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // reflected crc, byte 0 first, low nine bits give the index
  function automatic logic [8:0] hash_of(input saf_addr_t d);
    logic [31:0] c;
    c = `SAF_CRC_INIT;
    for (int i = 0; i < 48; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ `SAF_CRC_POLY : c >> 1;
    return c[8:0];
  endfunction
  function automatic saf_addr_t paddr(input int k);
    return {k[7:0], 32'h9ABC_DEF0, k[7:0] ^ 8'h01};
  endfunction
  // offers a descriptor; destinations keep coming to prove the detach
  task automatic offer(input logic [10:0] size, input logic first, input logic last, input logic bad);
    @(posedge clk_in);
    setup_req_in <= 1'b1;
    setup_buf_size_in <= size;
    setup_first_seg_in <= first;
    setup_last_seg_in <= last;
    @(posedge clk_in);
    setup_req_in <= 1'b0;
    rx_da_valid_in <= !bad;
    #1 check({setup_bad_out, tx_suppress_out}, {bad, !bad});
    if (!bad) begin
      // a start gate is still closed, so no word may be asked for and receive stays attached
      repeat (4) @(posedge clk_in);
      #1 check({word_ready_out, rx_detach_out, tx_suppress_out}, 3'b001);
      @(posedge clk_in);
      {tx_queue_empty_in, rx_frame_active_in, tx_running_in} <= 3'b101;
      for (int i = 0; i < 200 && wb_valid_out !== 1'b1; i++) begin
        @(posedge clk_in);
        #1;
      end
      check({wb_valid_out, rx_detach_out, wb_status_out}, {2'b11, `SAF_CLOSE_STATUS});
    end
    @(posedge clk_in);
    rx_da_valid_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic judge(input saf_addr_t da, input logic exp);
    @(posedge clk_in);
    rx_da_valid_in <= 1'b1;
    rx_da_in <= da;
    @(posedge clk_in);
    rx_da_valid_in <= 1'b0;
    #1 check({filt_valid_out, filt_accept_out}, {1'b1, exp});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {setup_req_in, setup_first_seg_in, setup_last_seg_in, rx_frame_active_in, hash_sel_in} = '0;
    {inverse_in, rx_da_valid_in, tx_queue_empty_in, rstn_in} = '0;
    {tx_running_in, stall} = 2'b11;
    setup_buf_size_in = '0;
    rx_da_in = '0;
    miss = {8'h20, 32'h9ABC_DEF0, 8'h21};
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    #1 check(wb_status_out, 32'h0000_0000);
    offer(11'h0BF, 1'b0, 1'b0, 1'b1);
    offer(`SAF_SETUP_BYTES, 1'b1, 1'b0, 1'b1);
    offer(`SAF_SETUP_BYTES, 1'b0, 1'b1, 1'b1);
    // perfect table with junk in the ignored upper halves
    for (int k = 0; k < 16; k++) begin
      a = paddr(k);
      for (int j = 0; j < 3; j++) mem[3 * k + j] = {16'hBEEF, a[16 * j +: 16]};
    end
    offer(`SAF_SETUP_BYTES, 1'b0, 1'b0, 1'b0);
    judge(paddr(0), 1'b1);
    judge(paddr(15), 1'b1);
    judge(miss, 1'b0);
    @(posedge clk_in);
    inverse_in <= 1'b1;
    judge(paddr(7), 1'b0);
    judge(miss, 1'b1);
    @(posedge clk_in);
    inverse_in <= 1'b0;
    // hash table with one bucket set, unicast in words 39 to 41
    ma1 = 48'h0027_0025_0025;
    ma2 = 48'h8725_3F62_C5A3;
    uni = 48'h0876_3534_12A8;
    h1 = hash_of(ma1);
    for (int w = 0; w < 48; w++) mem[w] = 32'hDEAD_0000;
    mem[h1[8:4]][h1[3:0]] = 1'b1;
    for (int j = 0; j < 3; j++) mem[39 + j] = {16'hDEAD, uni[16 * j +: 16]};
    @(posedge clk_in);
    hash_sel_in <= 1'b1;
    stall <= 1'b0;
    // queued as if at ring start; a stopped transmit and a frame arriving hold it back
    rx_frame_active_in <= 1'b1;
    tx_running_in <= 1'b0;
    offer(`SAF_SETUP_BYTES, 1'b0, 1'b0, 1'b0);
    judge(ma1, 1'b1);
    judge(ma2, hash_of(ma2) == h1);
    judge(uni, 1'b1);
    judge(uni ^ 48'h0000_0100, 1'b0);
    judge(uni | 48'h0000_0001, hash_of(uni | 48'h0000_0001) == h1);
    give_verdict();
  end
endmodule // saf_filter_tb
